// ---- atx_host_model.sv ----
// Host processor model on the parallel bus: control, load, read, send.
// Drives everything just after a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module atx_host_model (
    // Clock and flags
    input wire logic clk,
    input wire logic idle,
    input wire logic [15:0] dout,
    // Bus and strobes
    output logic [15:0] bus,
    output logic cw_stb,
    output logic rd1_n,
    output logic rd2_n,
    output logic sel,
    output logic ld1,
    output logic ld2,
    output logic send_en
);
    initial begin
        bus = 16'h0000;
        {cw_stb, ld1, ld2, send_en, sel} = 5'h00;
        {rd1_n, rd2_n} = 2'h3;
    end
    // Released bus shows the inverse so stale data cannot pass
    task automatic cw(input logic [9:0] v);
        @(negedge clk);
        bus = {1'b0, v, 5'h00};
        cw_stb = 1'b1;
        @(negedge clk);
        cw_stb = 1'b0;
        bus = ~bus;
    endtask
    task automatic load(input logic [15:0] h1, input logic [15:0] h2);
        @(negedge clk);
        bus = h1;
        ld1 = 1'b1;
        @(negedge clk);
        ld1 = 1'b0;
        @(negedge clk);
        bus = h2;
        ld2 = 1'b1;
        @(negedge clk);
        ld2 = 1'b0;
        bus = ~bus;
    endtask
    // Called at a falling edge; both halves read to free the flag
    task automatic read1(output logic [15:0] a, output logic [15:0] b);
        rd1_n = 1'b0;
        sel = 1'b0;
        @(negedge clk);
        a = dout;
        sel = 1'b1;
        @(negedge clk);
        b = dout;
        rd1_n = 1'b1;
    endtask
    // Receiver 2, second half first: either order must free the flag
    task automatic read2(output logic [15:0] a, output logic [15:0] b);
        rd2_n = 1'b0;
        sel = 1'b1;
        @(negedge clk);
        a = dout;
        sel = 1'b0;
        @(negedge clk);
        b = dout;
        rd2_n = 1'b1;
    endtask
    task automatic send();
        @(negedge clk);
        send_en = 1'b1;
        do @(negedge clk); while (idle !== 1'b1);
        send_en = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- atx_params.svh ----
// Constants of the avionics serial transceiver: control word fields,
// reset values and bit/word timing counts in units of the sample tick.
// Assumes nothing; definitions only.
`ifndef ATX_PARAMS_SVH
`define ATX_PARAMS_SVH

// Control word: ten flops loaded from bus bits 14..5
`define ATX_CW_BUS_LSB 5
`define ATX_CW_BUS_MSB 14
`define ATX_CW_RESET 10'h001
`define ATX_CW_SELFTEST_N 0
`define ATX_CW_RX1_LAB_EN 1
`define ATX_CW_RX1_L9 2
`define ATX_CW_RX1_L10 3
`define ATX_CW_RX2_LAB_EN 4
`define ATX_CW_RX2_L9 5
`define ATX_CW_RX2_L10 6
`define ATX_CW_TX_EVEN 7
`define ATX_CW_TX_SLOW 8
`define ATX_CW_RX_SLOW 9

// Tick every clock (fast) or every 8 clocks (slow); ten ticks per bit
`define ATX_SLOW_TICK_LAST 3'h7
`define ATX_BIT_LAST 6'h09
`define ATX_HALF_TICKS 6'h05
`define ATX_GAP_LAST 6'h27
`define ATX_SPACE_MIN 5'h08
`define ATX_SPACE_MAX 5'h0c
`define ATX_GAP_NULLS 2'h3
`define ATX_GAP_DIV_LAST 4'h9
`define ATX_LAST_BIT 6'h1f
`define ATX_TX_LAST_BIT 6'h1f
`define ATX_FIFO_DEPTH 8
`define ATX_FIFO_WIDTH 31

`endif

// ---- atx_pkg.sv ----
// Types and word packing helpers shared by the transceiver files.
// Assumes serial bit n sits at word index n-1.
package atx_pkg;

    typedef enum logic {ATX_RX_GAP, ATX_RX_RECV} atx_rx_state_t;
    typedef enum logic [1:0] {ATX_TX_IDLE, ATX_TX_DATA, ATX_TX_GAP} atx_tx_state_t;

    typedef struct packed {
        atx_rx_state_t state;
        logic [9:0] ones;
        logic [9:0] zeros;
        logic [9:0] nulls;
        logic qual;
        logic [4:0] space;
        logic [5:0] bit_cnt;
        logic [31:0] shift;
        logic [3:0] gap_div;
        logic [1:0] gap_cnt;
        logic [31:0] held;
        logic ready;
        logic rd_lo;
        logic rd_hi;
    } atx_rx_t;

    // First half-word layout of a 32-bit word
    function automatic logic [15:0] atx_half1(input logic [31:0] w);
        logic [15:0] h;
        h = {w[12:8], w[30], w[29], w[31], 8'h00};
        for (int i = 0; i < 8; i++) begin
            h[7-i] = w[i];
        end
        return h;
    endfunction

    // Builds the 31 stored bits from the two loaded half-words
    function automatic logic [30:0] atx_tx_word(input logic [15:0] h1, input logic [15:0] h2);
        logic [30:0] w;
        w = '0;
        for (int i = 0; i < 8; i++) begin
            w[i] = h1[7-i];
        end
        w[12:8] = h1[15:11];
        w[28:13] = h2;
        w[29] = h1[9];
        w[30] = h1[10];
        return w;
    endfunction

endpackage

// ---- atx_transceiver.sv ----
// Dual receiver / single transmitter serial word engine with its
// transmit FIFO. Host bus inputs are synchronous to SYS_CLK.
//
// Summary of operation
// - Ten control flops capture bus bits 14..5 on each control strobe pulse.
// - Control bit 5 low loops transmitter outputs back into the receivers.
// - Control bit 6 high: receiver 1 needs bits 9,10 equal control 7,8.
// - Control bit 9 high: receiver 2 needs bits 9,10 equal control 10,11.
// - Control bit 12 picks transmit parity: 0 odd, 1 even.
// - Control bit 13 picks transmit data clock, master divided 10 or 80.
// - Control bit 14 picks receive sample clock, master divided 1 or 8.
// - First half-word packs serial bits 13..9, 31, 30, 32, 1..8.
// - Second half-word carries serial bits 29 down to 14.
// - Line states count only after three identical consecutive samples.
// - Data bit needs one/zero in upper samples then null in lower.
// - Word-gap null needs three nulls in upper and lower samples.
// - Data bits must be 8 to 12 samples apart or the word drops.
// - After a word, sample null every ten ticks; three nulls re-arm.
// - Received bit 32 shows 0 when ones including bit 32 are odd.
// - Thirty-two bits raise word complete, setting ready if label passes.
// - Ready stays low until both half-words are read via enable and select.
// - Host loads first half then second; full word enters next FIFO slot.
// - FIFO holds eight words and ignores loads while full.
// - Send enable moves head word out; first bit follows promptly.
// - Bit is ten periods, half data half null; word gap forty.
// - Word counter raises transmitter idle when all loaded words are sent.
// - Transmitter idle drops as soon as a word is loaded.
// - Receiver 2 reaches the bus only while receiver 1 enable is high.
// - Global clear stops traffic, empties FIFO and flags, keeps control.
`timescale 1ns/1ps
`default_nettype none
`include "atx_params.svh"

module atx_fifo #(
    parameter int WIDTH = 31,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [CW-1:0] cnt;
    } atx_fifo_st_t;

    atx_fifo_st_t s_ff;
    atx_fifo_st_t nxt_s;
    logic push;
    logic pop;

    assign in_ready = (s_ff.cnt != CW'(DEPTH));
    assign out_valid = (s_ff.cnt != '0);
    assign out_data = s_ff.mem[s_ff.rd];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        nxt_s = s_ff;
        if (push) begin
            nxt_s.mem[s_ff.wr] = in_data;
            nxt_s.wr = (s_ff.wr == AW'(DEPTH - 1)) ? '0 : s_ff.wr + AW'(1);
        end
        if (pop) begin
            nxt_s.rd = (s_ff.rd == AW'(DEPTH - 1)) ? '0 : s_ff.rd + AW'(1);
        end
        nxt_s.cnt = s_ff.cnt + CW'(push) - CW'(pop);
        if (clear) begin
            nxt_s.wr = '0;
            nxt_s.rd = '0;
            nxt_s.cnt = '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////

module atx_transceiver (
    // Clock and resets
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic GLOBAL_CLEAR_N,
    // Host data bus, split two-way pin
    input wire logic [15:0] BUS_DATA_IN,
    output logic [15:0] BUS_DATA_OUT,
    output logic BUS_DATA_OE,
    // Host control strobes
    input wire logic CONTROL_WORD_STROBE,
    input wire logic RX1_READ_ENABLE_N,
    input wire logic RX2_READ_ENABLE_N,
    input wire logic HALF_WORD_SELECT,
    input wire logic TX_LOAD_FIRST_HALF,
    input wire logic TX_LOAD_SECOND_HALF,
    input wire logic TX_SEND_ENABLE,
    // Host flags
    output logic RX1_WORD_READY_N,
    output logic RX2_WORD_READY_N,
    output logic TX_IDLE,
    // Line comparator inputs and line outputs
    input wire logic RX1_LINE_POS,
    input wire logic RX1_LINE_NEG,
    input wire logic RX2_LINE_POS,
    input wire logic RX2_LINE_NEG,
    output logic LINE_OUT_POS,
    output logic LINE_OUT_NEG
);
    import atx_pkg::*;

    typedef struct packed {
        logic [9:0] ctrl;
        logic strobe_prev;
        logic ld1_prev;
        logic ld2_prev;
        logic [15:0] half1;
        logic half1_ok;
        logic [2:0] tx_div;
        logic [2:0] rx_div;
        atx_tx_state_t tx_state;
        logic [31:0] tx_shift;
        logic [5:0] tx_bits;
        logic [5:0] tx_cnt;
        logic [3:0] pending;
        logic idle;
        logic pos;
        logic neg;
        logic [15:0] bus_out;
        atx_rx_t [1:0] rx;
    } atx_state_t;

    atx_state_t s_ff;
    atx_state_t nxt_s;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [30:0] fifo_out_data;
    logic [30:0] load_word;

    ////////////////////////////////////////////////////////////////////////////
    // One receiver, advanced by one clock
    function automatic atx_rx_t rx_step(input atx_rx_t r, input logic lp, input logic ln,
                                        input logic tick, input logic lab_en,
                                        input logic [1:0] lab, input logic rd_lo,
                                        input logic rd_hi);
        atx_rx_t n;
        logic cond;
        logic ev;
        logic wgap;
        logic done;
        logic abort;
        logic [31:0] w;
        n = r;
        done = 1'b0;
        abort = 1'b0;
        w = r.shift;
        if (tick) begin
            n.ones = {r.ones[8:0], lp & ~ln};
            n.zeros = {r.zeros[8:0], ln & ~lp};
            n.nulls = {r.nulls[8:0], ~lp & ~ln};
            cond = ((&n.ones[9:7]) | (&n.zeros[9:7])) & (&n.nulls[2:0]);
            ev = cond & ~r.qual;
            n.qual = cond;
            wgap = (&n.nulls[9:7]) & (&n.nulls[2:0]);
            if (r.space != 5'h1f) begin
                n.space = r.space + 5'h01;
            end
            if (r.state == ATX_RX_GAP) begin
                n.gap_div = (r.gap_div == `ATX_GAP_DIV_LAST) ? 4'h0 : r.gap_div + 4'h1;
                if (r.gap_div == `ATX_GAP_DIV_LAST) begin
                    n.gap_cnt = wgap ? r.gap_cnt + 2'h1 : 2'h0;
                    if (wgap && (r.gap_cnt + 2'h1 == `ATX_GAP_NULLS)) begin
                        n.state = ATX_RX_RECV;
                        n.bit_cnt = '0;
                    end
                end
            end else if (ev) begin
                if ((r.bit_cnt != '0) &&
                    ((r.space < `ATX_SPACE_MIN) || (r.space > `ATX_SPACE_MAX))) begin
                    abort = 1'b1;
                end else begin
                    n.shift[r.bit_cnt[4:0]] = n.ones[9];
                    n.space = '0;
                    n.bit_cnt = r.bit_cnt + 6'h01;
                    if (r.bit_cnt == `ATX_LAST_BIT) begin
                        done = 1'b1;
                        w = n.shift;
                        w[31] = ~(^n.shift);
                        abort = 1'b1;
                    end
                end
            end else if ((r.bit_cnt != '0) && (r.space > `ATX_SPACE_MAX)) begin
                abort = 1'b1;
            end
            if (abort) begin
                n.state = ATX_RX_GAP;
                n.gap_cnt = '0;
                n.gap_div = '0;
            end
        end
        if (r.ready) begin
            n.rd_lo = r.rd_lo | rd_lo;
            n.rd_hi = r.rd_hi | rd_hi;
            if (n.rd_lo & n.rd_hi) begin
                n.ready = 1'b0;
            end
        end
        // A fresh word beats a clearing read in the same cycle
        if (done && (!lab_en || ({w[9], w[8]} == lab))) begin
            n.held = w;
            n.ready = 1'b1;
            n.rd_lo = 1'b0;
            n.rd_hi = 1'b0;
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Transmit buffer
    atx_fifo #(
        .WIDTH(`ATX_FIFO_WIDTH),
        .DEPTH(`ATX_FIFO_DEPTH)
    ) u_fifo (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .clear(~GLOBAL_CLEAR_N),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(load_word),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    assign load_word = atx_tx_word(s_ff.half1, BUS_DATA_IN);
    assign fifo_out_ready = (s_ff.tx_state == ATX_TX_IDLE) & TX_SEND_ENABLE & GLOBAL_CLEAR_N;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic tx_tick;
        logic rx_tick;
        logic rd1;
        logic rd2;
        logic pushed;
        logic sent;
        logic lp1;
        logic ln1;
        logic lp2;
        logic ln2;
        logic [31:0] src;
        nxt_s = s_ff;
        fifo_in_valid = 1'b0;
        pushed = 1'b0;
        sent = 1'b0;
        lp1 = 1'b0;
        ln1 = 1'b0;
        lp2 = 1'b0;
        ln2 = 1'b0;
        // Tick is master/1 or master/8; ten ticks make the data clock
        tx_tick = !s_ff.ctrl[`ATX_CW_TX_SLOW] || (s_ff.tx_div == `ATX_SLOW_TICK_LAST);
        rx_tick = !s_ff.ctrl[`ATX_CW_RX_SLOW] || (s_ff.rx_div == `ATX_SLOW_TICK_LAST);
        nxt_s.tx_div = s_ff.tx_div + 3'h1;
        nxt_s.rx_div = s_ff.rx_div + 3'h1;
        nxt_s.strobe_prev = CONTROL_WORD_STROBE;
        nxt_s.ld1_prev = TX_LOAD_FIRST_HALF;
        nxt_s.ld2_prev = TX_LOAD_SECOND_HALF;
        if (CONTROL_WORD_STROBE && !s_ff.strobe_prev) begin
            nxt_s.ctrl = BUS_DATA_IN[`ATX_CW_BUS_MSB:`ATX_CW_BUS_LSB];
        end

        // Host loads; a second half without a first is dropped
        if (TX_LOAD_FIRST_HALF && !s_ff.ld1_prev) begin
            nxt_s.half1 = BUS_DATA_IN;
            nxt_s.half1_ok = 1'b1;
        end
        if (TX_LOAD_SECOND_HALF && !s_ff.ld2_prev) begin
            fifo_in_valid = s_ff.half1_ok;
            pushed = s_ff.half1_ok & fifo_in_ready;
            nxt_s.half1_ok = 1'b0;
        end

        // Transmitter
        case (s_ff.tx_state)
            ATX_TX_IDLE: begin
                if (fifo_out_ready && fifo_out_valid) begin
                    nxt_s.tx_state = ATX_TX_DATA;
                    nxt_s.tx_shift = {s_ff.ctrl[`ATX_CW_TX_EVEN] ? ^fifo_out_data
                                      : ~(^fifo_out_data), fifo_out_data};
                    nxt_s.tx_bits = '0;
                    nxt_s.tx_cnt = '0;
                end
            end
            ATX_TX_DATA: begin
                if (!TX_SEND_ENABLE) begin
                    nxt_s.tx_state = ATX_TX_IDLE;
                    sent = 1'b1;
                end else if (tx_tick) begin
                    nxt_s.tx_cnt = s_ff.tx_cnt + 6'h01;
                    if (s_ff.tx_cnt == `ATX_BIT_LAST) begin
                        nxt_s.tx_cnt = '0;
                        nxt_s.tx_bits = s_ff.tx_bits + 6'h01;
                        nxt_s.tx_shift = {1'b0, s_ff.tx_shift[31:1]};
                        if (s_ff.tx_bits == `ATX_TX_LAST_BIT) begin
                            nxt_s.tx_state = ATX_TX_GAP;
                        end
                    end
                end
            end
            ATX_TX_GAP: begin
                if (tx_tick) begin
                    nxt_s.tx_cnt = s_ff.tx_cnt + 6'h01;
                    if (s_ff.tx_cnt == `ATX_GAP_LAST) begin
                        nxt_s.tx_state = ATX_TX_IDLE;
                        sent = 1'b1;
                    end
                end
            end
            default: begin
                nxt_s.tx_state = ATX_TX_IDLE;
            end
        endcase
        nxt_s.pending = s_ff.pending + 4'(pushed) - 4'(sent);
        nxt_s.idle = (nxt_s.pending == '0) && !pushed;
        nxt_s.pos = (nxt_s.tx_state == ATX_TX_DATA) && (nxt_s.tx_cnt < `ATX_HALF_TICKS)
                    && nxt_s.tx_shift[0];
        nxt_s.neg = (nxt_s.tx_state == ATX_TX_DATA) && (nxt_s.tx_cnt < `ATX_HALF_TICKS)
                    && !nxt_s.tx_shift[0];

        // Receivers; self test feeds receiver 2 the complement
        if (!s_ff.ctrl[`ATX_CW_SELFTEST_N]) begin
            lp1 = s_ff.pos;
            ln1 = s_ff.neg;
            lp2 = s_ff.neg;
            ln2 = s_ff.pos;
        end else begin
            lp1 = RX1_LINE_POS;
            ln1 = RX1_LINE_NEG;
            lp2 = RX2_LINE_POS;
            ln2 = RX2_LINE_NEG;
        end
        rd1 = !RX1_READ_ENABLE_N;
        rd2 = !RX2_READ_ENABLE_N && RX1_READ_ENABLE_N;
        nxt_s.rx[0] = rx_step(s_ff.rx[0], lp1, ln1, rx_tick, s_ff.ctrl[`ATX_CW_RX1_LAB_EN],
                              {s_ff.ctrl[`ATX_CW_RX1_L10], s_ff.ctrl[`ATX_CW_RX1_L9]},
                              rd1 && !HALF_WORD_SELECT, rd1 && HALF_WORD_SELECT);
        nxt_s.rx[1] = rx_step(s_ff.rx[1], lp2, ln2, rx_tick, s_ff.ctrl[`ATX_CW_RX2_LAB_EN],
                              {s_ff.ctrl[`ATX_CW_RX2_L10], s_ff.ctrl[`ATX_CW_RX2_L9]},
                              rd2 && !HALF_WORD_SELECT, rd2 && HALF_WORD_SELECT);
        src = rd1 ? s_ff.rx[0].held : s_ff.rx[1].held;
        nxt_s.bus_out = HALF_WORD_SELECT ? src[28:13] : atx_half1(src);

        // Global clear wipes traffic and flags but keeps the control word
        if (!GLOBAL_CLEAR_N) begin
            nxt_s = '0;
            nxt_s.ctrl = s_ff.ctrl;
            nxt_s.strobe_prev = s_ff.strobe_prev;
            nxt_s.idle = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s_ff <= '0;
            s_ff.ctrl <= `ATX_CW_RESET;
            s_ff.idle <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign BUS_DATA_OUT = s_ff.bus_out;
    assign BUS_DATA_OE = !RX1_READ_ENABLE_N || !RX2_READ_ENABLE_N;
    assign RX1_WORD_READY_N = !s_ff.rx[0].ready;
    assign RX2_WORD_READY_N = !s_ff.rx[1].ready;
    assign TX_IDLE = s_ff.idle;
    assign LINE_OUT_POS = s_ff.pos;
    assign LINE_OUT_NEG = s_ff.neg;
endmodule

`default_nettype wire

// ---- atx_transceiver_assertions.sv ----
// Concurrent checks on the transceiver top ports.
// Assumes one clock domain; control word is mirrored from the strobe.
`timescale 1ns/1ps
`default_nettype none
module atx_transceiver_assertions (
    // Clock and resets
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic GLOBAL_CLEAR_N,
    // Host side
    input wire logic [15:0] BUS_DATA_IN,
    input wire logic BUS_DATA_OE,
    input wire logic CONTROL_WORD_STROBE,
    input wire logic RX1_READ_ENABLE_N,
    input wire logic RX2_READ_ENABLE_N,
    input wire logic TX_LOAD_FIRST_HALF,
    input wire logic TX_LOAD_SECOND_HALF,
    input wire logic TX_SEND_ENABLE,
    input wire logic RX1_WORD_READY_N,
    input wire logic RX2_WORD_READY_N,
    input wire logic TX_IDLE,
    // Line side
    input wire logic LINE_OUT_POS,
    input wire logic LINE_OUT_NEG
);
    typedef struct packed {
        logic [9:0] ctl;
        logic stb;
    } atx_chk_t;
    atx_chk_t st_ff;
    atx_chk_t nxt_st;
    logic drv;
    assign drv = LINE_OUT_POS || LINE_OUT_NEG;
    // Mirror of the control word, needed to know the bit rate
    always_comb begin
        nxt_st = st_ff;
        nxt_st.stb = CONTROL_WORD_STROBE;
        if (CONTROL_WORD_STROBE && !st_ff.stb) begin
            nxt_st.ctl = BUS_DATA_IN[14:5];
        end
    end
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_ff <= {10'h001, 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);
    property p_oe;
        BUS_DATA_OE == (!RX1_READ_ENABLE_N || !RX2_READ_ENABLE_N);
    endproperty
    a_oe: assert property (p_oe) else $error("bus enable mismatch");
    property p_excl;
        !(LINE_OUT_POS && LINE_OUT_NEG);
    endproperty
    a_excl: assert property (p_excl) else $error("both line outputs high");
    // Only a push preceded by a fresh first-half strobe counts
    property p_load;
        $rose(TX_LOAD_SECOND_HALF) && TX_IDLE && GLOBAL_CLEAR_N
            && $past(TX_LOAD_FIRST_HALF, 2) && !$past(TX_LOAD_FIRST_HALF, 3)
            && !$past(TX_LOAD_SECOND_HALF, 2) |-> ##[1:2] !TX_IDLE;
    endproperty
    a_load: assert property (p_load) else $error("idle flag kept after load");
    property p_bit;
        disable iff (SYS_RST || !GLOBAL_CLEAR_N)
        $rose(drv) && !st_ff.ctl[8] |-> drv[*5] ##1 !drv;
    endproperty
    a_bit: assert property (p_bit) else $error("data half length wrong");
    property p_null;
        disable iff (SYS_RST || !GLOBAL_CLEAR_N)
        $fell(drv) && !st_ff.ctl[8] |-> (!drv)[*5];
    endproperty
    a_null: assert property (p_null) else $error("null half too short");
    property p_first;
        disable iff (SYS_RST || !GLOBAL_CLEAR_N)
        $rose(TX_SEND_ENABLE) && !TX_IDLE && !st_ff.ctl[8] |-> ##[1:25] drv;
    endproperty
    a_first: assert property (p_first) else $error("first bit late");
    property p_clear;
        !GLOBAL_CLEAR_N |=> TX_IDLE && RX1_WORD_READY_N && RX2_WORD_READY_N && !drv;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not settle");
    property p_hold1;
        !RX1_WORD_READY_N && RX1_READ_ENABLE_N && GLOBAL_CLEAR_N |=> !RX1_WORD_READY_N;
    endproperty
    a_hold1: assert property (p_hold1) else $error("ready 1 dropped unread");
    property p_hold2;
        !RX2_WORD_READY_N && RX2_READ_ENABLE_N && GLOBAL_CLEAR_N |=> !RX2_WORD_READY_N;
    endproperty
    a_hold2: assert property (p_hold2) else $error("ready 2 dropped unread");
    c_idle: cover property ($rose(TX_IDLE));
    c_ready: cover property ($fell(RX1_WORD_READY_N));
    c_clear: cover property (!GLOBAL_CLEAR_N);
    c_zero: cover property ($rose(LINE_OUT_NEG));
endmodule
`default_nettype wire

// ---- atx_transceiver_tb.sv ----
// Bench: self-test loopback words, FIFO limit, label filter, master clear.
// Assumes the host model and the checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module atx_transceiver_tb;
    logic SYS_CLK;
    logic SYS_RST;
    logic GLOBAL_CLEAR_N;
    logic [15:0] bus;
    logic [15:0] dout;
    logic cw_stb, rd1_n, rd2_n, sel, ld1, ld2, send_en;
    logic rdy1_n, rdy2_n, idle, out_pos, out_neg;
    logic [15:0] r1, r2, r3, r4;
    logic [31:0] ew;
    logic [31:0] lw;
    logic [31:0] exp_q[$];
    int n_fail, checks_done, cyc;
    atx_transceiver u_atx_transceiver (
        .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .GLOBAL_CLEAR_N(GLOBAL_CLEAR_N),
        .BUS_DATA_IN(bus), .BUS_DATA_OUT(dout), .BUS_DATA_OE(),
        .CONTROL_WORD_STROBE(cw_stb), .RX1_READ_ENABLE_N(rd1_n),
        .RX2_READ_ENABLE_N(rd2_n), .HALF_WORD_SELECT(sel),
        .TX_LOAD_FIRST_HALF(ld1), .TX_LOAD_SECOND_HALF(ld2),
        .TX_SEND_ENABLE(send_en), .RX1_WORD_READY_N(rdy1_n),
        .RX2_WORD_READY_N(rdy2_n), .TX_IDLE(idle),
        .RX1_LINE_POS(1'b0), .RX1_LINE_NEG(1'b0),
        .RX2_LINE_POS(1'b0), .RX2_LINE_NEG(1'b0),
        .LINE_OUT_POS(out_pos), .LINE_OUT_NEG(out_neg)
    );
    atx_host_model u_atx_host_model (
        .clk(SYS_CLK), .idle, .dout, .bus, .cw_stb, .rd1_n, .rd2_n,
        .sel, .ld1, .ld2, .send_en
    );
    initial SYS_CLK = 1'b0;
    always #2.5 SYS_CLK = ~SYS_CLK;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] half1(input logic [31:0] w);
        logic [15:0] h;
        h = {w[12:8], w[30], w[29], w[31], 8'h00};
        for (int i = 0; i < 8; i++) h[7-i] = w[i];
        return h;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (n_fail == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Parity slot of the loaded half is flipped: the device must regenerate it
    task automatic run(input logic [9:0] cw, input int n, input int bad);
        logic [31:0] w;
        for (int i = 0; i < n; i++) begin
            w = {cw[7], 31'($urandom)};
            if (cw[1]) w[9:8] = (i == bad) ? ~cw[3:2] : cw[3:2];
            u_atx_host_model.load(half1(w) ^ 16'h0100, w[28:13]);
            if (i < 8 && i != bad) exp_q.push_back(w);
            if (i < 8) lw = w;
            chk(idle, 1'b0);
        end
        u_atx_host_model.send();
        chk(exp_q.size(), 0);
    endtask
    // Receive side: every receiver 1 ready word is read and matched to the oldest note
    initial forever begin
        @(negedge SYS_CLK);
        if (rdy1_n === 1'b0) begin
            u_atx_host_model.read1(r1, r2);
            ew = (exp_q.size() != 0) ? exp_q.pop_front() : 32'hx;
            chk({r1, r2}, {half1(ew), ew[28:13]});
        end
    end
    always @(posedge SYS_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_sim();
        end
    end
    initial begin
        SYS_RST = 1'b1;
        GLOBAL_CLEAR_N = 1'b1;
        void'($urandom(32'h4336));
        repeat (6) @(negedge SYS_CLK);
        SYS_RST = 1'b0;
        chk({idle, rdy1_n}, 2'b11);
        u_atx_host_model.cw(10'h000);
        run(10'h000, 9, -1);
        chk(rdy2_n, 1'b0);
        // Self test feeds receiver 2 the complement; parity sense is kept
        u_atx_host_model.read2(r3, r4);
        chk({r4, r3}, {half1({lw[31], ~lw[30:0]}), ~lw[28:13]});
        chk(rdy2_n, 1'b1);
        u_atx_host_model.cw(10'h086);
        run(10'h086, 3, 1);
        u_atx_host_model.load(16'h1234, 16'h5678);
        fork
            u_atx_host_model.send();
            begin
                repeat (60) @(negedge SYS_CLK);
                GLOBAL_CLEAR_N = 1'b0;
                @(negedge SYS_CLK);
                GLOBAL_CLEAR_N = 1'b1;
            end
        join
        chk({out_pos, out_neg, rdy1_n, rdy2_n, idle}, 5'h07);
        u_atx_host_model.cw(10'h386);
        // Clear disarms the receivers; three slow gap checks re-arm them
        repeat (300) @(negedge SYS_CLK);
        run(10'h386, 1, -1);
        end_sim();
    end
endmodule
bind atx_transceiver atx_transceiver_assertions u_atx_transceiver_assertions (
    .SYS_CLK, .SYS_RST, .GLOBAL_CLEAR_N, .BUS_DATA_IN, .BUS_DATA_OE,
    .CONTROL_WORD_STROBE, .RX1_READ_ENABLE_N, .RX2_READ_ENABLE_N,
    .TX_LOAD_FIRST_HALF, .TX_LOAD_SECOND_HALF, .TX_SEND_ENABLE,
    .RX1_WORD_READY_N, .RX2_WORD_READY_N, .TX_IDLE, .LINE_OUT_POS, .LINE_OUT_NEG
);
`default_nettype wire
